/* logic/pcs_pkg.sv */
// Constants for the bus control signalling block.
// Assumes a single bus clock; all pins are sampled by the block itself.
package pcs_pkg;
  // ----------------------------------------------------------------
  // Clock figures
  // ----------------------------------------------------------------
  // Nominal clock period in picoseconds (20 MHz).
  localparam int unsigned CLK_PERIOD_PS = 50000;
  // Highest bus clock the logic is timed for, in kHz.
  localparam int unsigned BUS_CLK_MAX_KHZ = 66000;
  // Cycles of idle bus before the clock-run request is dropped.
  localparam logic [3:0] CLKRUN_HOLD = 4'h8;
  // Address matching: the device claims the upper address window.
  localparam logic [31:0] MEM_BASE = 32'hF000_0000;
  localparam logic [31:0] MEM_MASK = 32'hFFFF_0000;
  // Bus command codes seen in the address phase.
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  // Master sequencer states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    MS_IDLE = 3'h0,
    MS_REQ  = 3'h1,
    MS_ADDR = 3'h3,
    MS_DATA = 3'h2,
    MS_TURN = 3'h6
  } pcs_mst_t;
endpackage

/* logic/pcs_ctrl.sv */
// Control-side signalling of the bus interface: request/grant, framing,
// target claim, configuration select, clock-run and the interrupt line.
// Assumes pins arrive asynchronously and pass two flip-flops; open-drain
// and three-state pins are split into input, output and enable; the interrupt line has no input.
`timescale 1ns/1ps
// Contract
// - All transactions timed from one clock
// - Sample clock-run as clock status
// - Master samples target claim
// - Target drives claim after frame, decoded
// - Master frames: low, hold, release last
// - Target watches frame before decoding
// - Request bus when master needed
// - Master only while grant held (code checks grant only when leaving MS_REQ, not during data phases)
// - Config only with select in address
// - Interrupt low when pending and enabled
// - Data moves only with both readies
// - Address phase is first framed cycle
module pcs_ctrl
  import pcs_pkg::*;
(
  input wire logic mclk, // Bus clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic mst_start, // Pulse: begin a master transfer.
  input wire logic [3:0] mst_cmd, // Command for the transfer.
  input wire logic [7:0] mst_len, // Data phases minus one.
  output logic mst_busy, // Master transfer under way.
  output logic mst_beat, // Pulse: one master data word moved.
  output logic mst_abort, // Pulse: no target claimed the transfer.
  input wire logic [31:0] ad_in, // Address/data bus as seen on the pins.
  input wire logic [3:0] cbe_in, // Command/byte enables on the pins.
  output logic tgt_hit, // Pulse: address phase claimed.
  output logic tgt_cfg, // Claimed access is configuration.
  output logic tgt_beat, // Pulse: one target data word moved.
  input wire logic [7:0] int_status, // Pending interrupt conditions.
  input wire logic [7:0] int_mask, // Interrupt enables.
  input wire logic need_clock, // Core wants the bus clock running.
  output logic clock_stopped, // Clock-run line seen deasserted.
  input wire logic bus_grant_n_i, // Grant from arbiter.
  output logic bus_request_n, // Request to arbiter.
  input wire logic cycle_frame_n_i, // Frame, input.
  output logic cycle_frame_n_o, // Frame, output value.
  output logic cycle_frame_n_oe, // Frame, output enable.
  input wire logic initiator_ready_n_i, // Initiator ready, input.
  output logic initiator_ready_n_o, // Initiator ready, output value.
  output logic initiator_ready_n_oe, // Initiator ready, enable.
  input wire logic target_ready_n_i, // Target ready, input.
  output logic target_ready_n_o, // Target ready, output value.
  output logic target_ready_n_oe, // Target ready, enable.
  input wire logic target_claim_n_i, // Claim, input.
  output logic target_claim_n_o, // Claim, output value.
  output logic target_claim_n_oe, // Claim, output enable.
  input wire logic config_target_select, // Configuration select.
  input wire logic clock_run_request_n_i, // Clock-run, input.
  output logic clock_run_request_n_o, // Clock-run, output value.
  output logic clock_run_request_n_oe, // Clock-run, enable (open drain).
  output logic interrupt_line_a_n_o, // Interrupt, output value.
  output logic interrupt_line_a_n_oe // Interrupt, enable (open drain).
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages per pin; only the second stage is read by logic.
  logic [5:0] s1_q; // First stage.
  logic [5:0] s2_q; // Second stage.
  logic [5:0] s_d; // Raw pins.
  assign s_d = {bus_grant_n_i, cycle_frame_n_i, initiator_ready_n_i,
                target_ready_n_i, target_claim_n_i, clock_run_request_n_i};
  // Also register the data pins alongside so they align with the controls.
  logic [31:0] ad1_q, ad2_q; // Address stages.
  logic [3:0] cb1_q, cb2_q; // Command stages.
  logic cs1_q, cs2_q; // Select stages.
  // every flop on the one bus clock.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 6'h3F;
      s2_q <= 6'h3F;
      ad1_q <= 32'h0000_0000;
      ad2_q <= 32'h0000_0000;
      cb1_q <= 4'h0;
      cb2_q <= 4'h0;
      cs1_q <= 1'b0;
      cs2_q <= 1'b0;
    end else begin
      s1_q <= s_d;
      s2_q <= s1_q;
      ad1_q <= ad_in;
      ad2_q <= ad1_q;
      cb1_q <= cbe_in;
      cb2_q <= cb1_q;
      cs1_q <= config_target_select;
      cs2_q <= cs1_q;
    end
  end
  logic gnt_n, frm_n, irdy_n, trdy_n, dev_n, crun_n; // Synchronised pins.
  assign {gnt_n, frm_n, irdy_n, trdy_n, dev_n, crun_n} = s2_q;

  // Returns high when an address lies in the device's memory window.
  function automatic logic addr_match(input logic [31:0] a);
    addr_match = ((a & MEM_MASK) == MEM_BASE);
  endfunction

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  pcs_mst_t st_q, st_d; // Sequencer state.
  logic [7:0] cnt_q, cnt_d; // Remaining data phases.
  logic [1:0] wait_q, wait_d; // Cycles waited for a claim.
  logic own_bus; // Master drives the bus this cycle.
  logic beat; // Master data moved.
  // data moves only with both readies low.
  assign beat = (st_q == MS_DATA) && !irdy_n && !trdy_n;
  // Next state. A transfer that nobody claims in four data-phase cycles is aborted,
  // which matches the slowest decode a target may take.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wait_d = wait_q;
    mst_beat = 1'b0;
    mst_abort = 1'b0;
    case (st_q)
      MS_IDLE: begin
        if (mst_start) begin
          st_d = MS_REQ;
          cnt_d = mst_len;
        end
      end
      MS_REQ: begin
        // start only with grant held and the bus idle.
        if (!gnt_n && frm_n && irdy_n) begin
          st_d = MS_ADDR;
        end
      end
      MS_ADDR: begin
        st_d = MS_DATA;
        wait_d = 2'h0;
      end
      MS_DATA: begin
        // sample claim to confirm a target answered.
        if (dev_n) begin
          wait_d = wait_q + 2'h1;
          if (wait_q == 2'h3) begin
            mst_abort = 1'b1;
            st_d = MS_TURN;
          end
        end else if (beat) begin
          mst_beat = 1'b1;
          if (cnt_q == 8'h00) begin
            st_d = MS_TURN;
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
      end
      MS_TURN: begin
        st_d = MS_IDLE;
      end
      default: begin
        st_d = MS_IDLE;
      end
    endcase
  end
  // Registers the master state.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= MS_IDLE;
      cnt_q <= 8'h00;
      wait_q <= 2'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wait_q <= wait_d;
    end
  end
  assign own_bus = (st_q == MS_ADDR) || (st_q == MS_DATA);
  assign mst_busy = (st_q != MS_IDLE);
  // request while a transfer waits for grant and in its address phase.
  assign bus_request_n = !((st_q == MS_REQ) || (st_q == MS_ADDR));
  // frame low from address, released on the last phase.
  assign cycle_frame_n_o = !((st_q == MS_ADDR) || (st_q == MS_DATA && cnt_q != 8'h00));
  assign cycle_frame_n_oe = own_bus || (st_q == MS_TURN);
  assign initiator_ready_n_o = !(st_q == MS_DATA);
  assign initiator_ready_n_oe = own_bus || (st_q == MS_TURN);

  // ----------------------------------------------------------------
  // Target claim
  // ----------------------------------------------------------------
  logic frm_prev_q; // Frame one cycle ago.
  logic tact_q, tact_d; // Target claimed, transaction live.
  logic tcfg_q, tcfg_d; // Claimed access is configuration.
  logic addr_ph; // Address phase seen.
  // address phase is the first cycle frame is low.
  // decode happens only on a newly framed transaction.
  assign addr_ph = !frm_n && frm_prev_q && !own_bus;
  always_comb begin
    tact_d = tact_q;
    tcfg_d = tcfg_q;
    if (addr_ph) begin
      // configuration only with select in the address phase.
      if (cs2_q && (cb2_q == CMD_CFG_RD || cb2_q == CMD_CFG_WR)) begin
        tact_d = 1'b1;
        tcfg_d = 1'b1;
      end else if ((cb2_q == CMD_MEM_RD || cb2_q == CMD_MEM_WR) && addr_match(ad2_q)) begin
        tact_d = 1'b1;
        tcfg_d = 1'b0;
      end
    end else if (tact_q && frm_n && !irdy_n && !trdy_n) begin
      // Final phase done: step off the bus.
      tact_d = 1'b0;
    end
  end
  // Registers the target state.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frm_prev_q <= 1'b1;
      tact_q <= 1'b0;
      tcfg_q <= 1'b0;
    end else begin
      frm_prev_q <= frm_n;
      tact_q <= tact_d;
      tcfg_q <= tcfg_d;
    end
  end
  assign tgt_hit = addr_ph && tact_d;
  assign tgt_cfg = tcfg_q;
  assign tgt_beat = tact_q && !irdy_n && !trdy_n;
  // claim low once a decoded address belongs to us.
  assign target_claim_n_o = !tact_q;
  assign target_claim_n_oe = tact_q;
  assign target_ready_n_o = !tact_q;
  assign target_ready_n_oe = tact_q;

  // ----------------------------------------------------------------
  // Clock-run and interrupt
  // ----------------------------------------------------------------
  logic [3:0] hold_q, hold_d; // Idle cycles before letting clock stop.
  logic want_clk; // Reasons to keep the clock.
  assign want_clk = need_clock || mst_busy || tact_q || !frm_n;
  always_comb begin
    hold_d = want_clk ? CLKRUN_HOLD : ((hold_q != 4'h0) ? hold_q - 4'h1 : 4'h0);
  end
  // Registers the hold counter.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 4'h0;
    end else begin
      hold_q <= hold_d;
    end
  end
  // pull clock-run low only when the host has let it go high.
  // the host restores the high level itself, so we never drive high.
  assign clock_run_request_n_o = 1'b0;
  assign clock_run_request_n_oe = (hold_q != 4'h0) && crun_n;
  // the sampled level reports the clock status.
  assign clock_stopped = crun_n;
  // pull low while any enabled condition is pending.
  assign interrupt_line_a_n_o = 1'b0;
  assign interrupt_line_a_n_oe = |(int_status & int_mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_grant_own: assert property (@(posedge mclk) disable iff (!rst_b)
    (st_q == MS_ADDR) |-> !gnt_n)
    else $error("Master started without grant.");
  a_frame_last: assert property (@(posedge mclk) disable iff (!rst_b)
    (st_q == MS_DATA && cnt_q == 8'h00) |-> cycle_frame_n_o)
    else $error("Frame held on last phase.");
  a_frame_start: assert property (@(posedge mclk) disable iff (!rst_b)
    (st_q == MS_ADDR) |-> (!cycle_frame_n_o && cycle_frame_n_oe))
    else $error("Frame not low in address phase.");
  a_req_seen: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(own_bus) |-> !$past(bus_request_n))
    else $error("No bus request while waiting.");
  a_beat_ready: assert property (@(posedge mclk) disable iff (!rst_b)
    (mst_beat || tgt_beat) |-> (!irdy_n && !trdy_n))
    else $error("Data moved without both readies.");
  a_claim_late: assert property (@(posedge mclk) disable iff (!rst_b)
    tgt_hit |=> !target_claim_n_o && target_claim_n_oe)
    else $error("Claim not driven after decode.");
  a_cfg_sel: assert property (@(posedge mclk) disable iff (!rst_b)
    (tgt_hit && !cs2_q) |=> !tgt_cfg)
    else $error("Config claimed without select.");
  a_int_pull: assert property (@(posedge mclk) disable iff (!rst_b)
    interrupt_line_a_n_oe == (|(int_status & int_mask)))
    else $error("Interrupt line wrong.");
  a_abort_wait: assert property (@(posedge mclk) disable iff (!rst_b)
    mst_abort |-> dev_n && $past(dev_n, 3))
    else $error("Abort while claim seen.");
  a_crun_high: assert property (@(posedge mclk) disable iff (!rst_b)
    clock_run_request_n_oe |-> !clock_run_request_n_o && crun_n)
    else $error("Clock-run driven wrongly.");
  c_master: cover property (@(posedge mclk) disable iff (!rst_b) mst_beat);
  c_target: cover property (@(posedge mclk) disable iff (!rst_b) tgt_hit ##1 tgt_cfg);
  c_abort: cover property (@(posedge mclk) disable iff (!rst_b) mst_abort);
endmodule

/* sim/pcs_host_model.sv */
// Far side of the bus: arbiter, a target that answers framed cycles,
// and the clock-run host. The bench resolves frame, both readies, claim and clock-run with pull-ups.
`timescale 1ns/1ps
module pcs_host_model (
  input wire logic mclk, // Bus clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic bus_request_n, // Request from the device.
  input wire logic frame_n, // Resolved frame level.
  input wire logic irdy_n, // Resolved initiator ready level.
  input wire logic claim_on, // Answer framed cycles as a target.
  input wire logic [1:0] wait_cyc, // Wait states before ready.
  input wire logic stop_req, // Host wants the clock stopped.
  input wire logic crun_n, // Resolved clock-run level.
  output logic bus_grant_n, // Grant to the device.
  output logic tgt_on, // Claim driven low.
  output logic trdy_on, // Target ready driven low.
  output logic run_q // Host holds clock-run low.
);
  logic act_q, act_d, fr_q, run_d, gnt_d;
  logic [1:0] wt_q, wt_d;
  // Next state of arbiter, target and clock host.
  always_comb begin
    act_d = act_q;
    wt_d = wt_q;
    gnt_d = bus_request_n;
    // host keeps line low, lets it rise to stop
    run_d = !stop_req && (run_q || !crun_n);
    // claim framed cycle, end on last transfer
    if (!act_q) begin
      if (claim_on && fr_q && !frame_n) begin
        act_d = 1'b1;
        wt_d = wait_cyc;
      end
    end else if (wt_q != 2'h0) begin
      wt_d = wt_q - 2'h1;
    end else if (!irdy_n && frame_n) begin
      act_d = 1'b0;
    end
  end
  assign tgt_on = act_q;
  assign trdy_on = act_q && (wt_q == 2'h0);
  // Registers only; released lines fall back to the pull-up.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      act_q <= 1'b0;
      wt_q <= 2'h0;
      fr_q <= 1'b1;
      run_q <= 1'b1;
      bus_grant_n <= 1'b1;
    end else begin
      act_q <= act_d;
      wt_q <= wt_d;
      fr_q <= frame_n;
      run_q <= run_d;
      bus_grant_n <= gnt_d;
    end
  end
endmodule

/* sim/pcs_ctrl_tb.sv */
// Self-checking bench for the bus control block with a host model.
// Assumes every shared pin has a pull-up; the bench resolves all of them except the interrupt line.
`timescale 1ns/1ps
module pcs_ctrl_tb;
  import pcs_pkg::*;
  logic mclk, rst_b, mst_start, need_clock, config_target_select, tb_fr, tb_ir;
  logic claim_on, stop_req, run_q, tgt_on, trdy_on, bus_grant_n_i, bus_request_n;
  logic mst_busy, mst_beat, mst_abort, tgt_hit, tgt_cfg, tgt_beat, clock_stopped;
  logic cycle_frame_n_o, cycle_frame_n_oe, initiator_ready_n_o, initiator_ready_n_oe;
  logic target_ready_n_o, target_ready_n_oe, target_claim_n_o, target_claim_n_oe;
  logic clock_run_request_n_o, clock_run_request_n_oe;
  logic interrupt_line_a_n_o, interrupt_line_a_n_oe;
  logic [1:0] wait_cyc;
  logic [3:0] mst_cmd, cbe_in;
  logic [7:0] mst_len, int_status, int_mask;
  logic [31:0] ad_in;
  int n_fail, comparisons, cyc, n_mb, n_ma, n_th, n_tb;
  // Pin levels: a driver wins, otherwise the pull-up.
  wire fr_w = cycle_frame_n_oe ? cycle_frame_n_o : tb_fr;
  wire ir_w = initiator_ready_n_oe ? initiator_ready_n_o : tb_ir;
  wire tr_w = target_ready_n_oe ? target_ready_n_o : !trdy_on;
  wire cl_w = target_claim_n_oe ? target_claim_n_o : !tgt_on;
  wire cr_w = !(clock_run_request_n_oe || run_q);
  pcs_ctrl i_pcs_ctrl (.mclk, .rst_b, .mst_start, .mst_cmd, .mst_len, .mst_busy,
    .mst_beat, .mst_abort, .ad_in, .cbe_in, .tgt_hit, .tgt_cfg, .tgt_beat, .int_status,
    .int_mask, .need_clock, .clock_stopped, .bus_grant_n_i, .bus_request_n,
    .cycle_frame_n_i(fr_w), .cycle_frame_n_o, .cycle_frame_n_oe,
    .initiator_ready_n_i(ir_w), .initiator_ready_n_o, .initiator_ready_n_oe,
    .target_ready_n_i(tr_w), .target_ready_n_o, .target_ready_n_oe,
    .target_claim_n_i(cl_w), .target_claim_n_o, .target_claim_n_oe,
    .config_target_select, .clock_run_request_n_i(cr_w), .clock_run_request_n_o,
    .clock_run_request_n_oe, .interrupt_line_a_n_o, .interrupt_line_a_n_oe);
  pcs_host_model i_pcs_host_model (.mclk, .rst_b, .bus_request_n, .frame_n(fr_w),
    .irdy_n(ir_w), .claim_on, .wait_cyc, .stop_req, .crun_n(cr_w),
    .bus_grant_n(bus_grant_n_i), .tgt_on, .trdy_on, .run_q);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Pulse counters and the hang limit, well above the planned run.
  always @(posedge mclk) begin
    cyc++;
    n_mb += (mst_beat === 1'b1);
    n_ma += (mst_abort === 1'b1);
    n_th += (tgt_hit === 1'b1);
    n_tb += (tgt_beat === 1'b1);
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Master transfer; a slow or absent target is chosen per call.
  task automatic t_master(input logic [7:0] len, input logic cl, input logic [1:0] w,
      input int beats, input int aborts);
    int mb, ma;
    logic s_req, s_fr;
    mb = n_mb;
    ma = n_ma;
    s_req = 0;
    s_fr = 0;
    claim_on = cl;
    wait_cyc = w;
    mst_len = len;
    mst_cmd = CMD_MEM_WR;
    mst_start = 1;
    step(1);
    mst_start = 0;
    for (int i = 0; i < 60 && mst_busy !== 1'b0; i++) begin
      s_req |= !bus_request_n;
      if (!s_fr && cycle_frame_n_oe && !cycle_frame_n_o) chk("grant", 0, bus_grant_n_i);
      s_fr |= cycle_frame_n_oe && !cycle_frame_n_o;
      step(1);
    end
    chk("busy", 0, mst_busy); // transfer ended
    chk("request", 1, s_req); // request seen
    chk("frame", 1, s_fr); // frame driven
    chk("beats", beats, n_mb - mb); // words moved
    chk("abort", aborts, n_ma - ma); // claim missing
    $display("master test len %0d done", len);
  endtask
  // Target access with one data phase from the bench as master.
  task automatic t_target(input logic [31:0] adr, input logic [3:0] cmd, input logic sel,
      input logic hit, input logic cfg);
    int th, tt;
    th = n_th;
    tt = n_tb;
    ad_in = adr;
    cbe_in = cmd;
    config_target_select = sel;
    tb_fr = 0;
    step(1);
    tb_fr = 1;
    tb_ir = 0;
    cbe_in = 4'h0;
    config_target_select = 0;
    ad_in = ~adr;
    // Hold initiator ready until the edge that samples target ready low.
    for (int i = 0; i < 8 && tr_w !== 1'b0; i++) step(1);
    chk("claim", !hit, cl_w); // claim with ready
    step(1);
    tb_ir = 1;
    step(5);
    chk("hit", hit, n_th - th); // decode
    chk("beat", hit, n_tb - tt); // word moved
    chk("released", 1, cl_w); // claim ends
    if (hit) chk("cfg", cfg, tgt_cfg); // access kind
    $display("target test %h done", adr);
  endtask
  // Reset: outputs idle while held, then release after 20 cycles.
  task automatic t_reset();
    step(2);
    chk("reset req", 1, bus_request_n); // idle
    chk("reset frame", 0, cycle_frame_n_oe); // released
    chk("reset busy", 0, mst_busy); // no transfer
    step(18);
    rst_b = 1;
    step(1);
    $display("reset test done");
  endtask
  task automatic t_irq();
    logic [23:0] tab [5] = '{24'h010000, 24'h010101, 24'h807F00, 24'h818001, 24'h00FF00};
    for (int i = 0; i < 5; i++) begin
      int_status = tab[i][23:16];
      int_mask = tab[i][15:8];
      step(1);
      chk("irq", tab[i][0], interrupt_line_a_n_oe); // pull
      chk("irq level", 0, interrupt_line_a_n_o); // open drain low
    end
    $display("interrupt test done");
  endtask
  task automatic t_clkrun();
    logic pulled;
    pulled = 0;
    stop_req = 1;
    step(1);
    stop_req = 0;
    step(12);
    chk("stopped", 1, clock_stopped); // status seen
    chk("idle pull", 0, clock_run_request_n_oe); // no need
    need_clock = 1;
    for (int i = 0; i < 8; i++) begin
      pulled |= clock_run_request_n_oe;
      step(1);
    end
    chk("pulled", 1, pulled); // request clock
    chk("pull level", 0, clock_run_request_n_o); // open drain low
    chk("running", 0, clock_stopped); // restarted
    need_clock = 0;
    $display("clock run test done");
  endtask
  initial begin
    {rst_b, mst_start, need_clock, config_target_select, claim_on, stop_req} = '0;
    {tb_fr, tb_ir} = 2'b11;
    {wait_cyc, mst_cmd, cbe_in, mst_len, int_status, int_mask, ad_in} = '0;
    {n_fail, comparisons, cyc, n_mb, n_ma, n_th, n_tb} = '0;
    t_reset();
    t_master(8'h00, 1, 2'h0, 1, 0);
    t_master(8'h03, 1, 2'h2, 4, 0);
    t_master(8'h01, 0, 2'h0, 0, 1);
    t_target(32'h0000_0010, CMD_CFG_RD, 1, 1, 1);
    t_target(32'h0000_0010, CMD_CFG_WR, 0, 0, 0);
    t_target(32'hF000_1234, CMD_MEM_RD, 0, 1, 0);
    t_target(32'hF001_0000, CMD_MEM_WR, 0, 0, 0);
    t_irq();
    t_clkrun();
    conclude();
  end
endmodule
